// File: hdl/rst_src_pkg.sv
// Constants, register map and types shared by the reset-source block
package rst_src_pkg;
   // Register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] OFS_CAUSE    = 8'h00;
   localparam logic [7:0] OFS_THRESH   = 8'h04;
   localparam logic [7:0] OFS_RSTFN    = 8'h08;
   localparam logic [7:0] OFS_SPCMD    = 8'h0c;
   localparam logic [7:0] OFS_STATUS   = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_CLR  = 8'h18;
   localparam logic [7:0] OFS_IRQ_EN   = 8'h1c;

   // Reset cause flag positions
   localparam int CAUSE_CTRL = 3;
   localparam int CAUSE_UVR  = 2;
   localparam int CAUSE_THR  = 1;
   localparam int CAUSE_WDT  = 0;

   // Status flag positions
   localparam int STAT_TIMEOUT   = 0;
   localparam int STAT_POWERDOWN = 1;

   // Interrupt event positions
   localparam int EV_CTRL    = 0;
   localparam int EV_UVR     = 1;
   localparam int EV_THR     = 2;
   localparam int EV_WDTCODE = 3;
   localparam int EV_WDT     = 4;
   localparam int EV_IAP     = 5;
   localparam int EV_W       = 6;

   // Threshold select codes
   localparam logic [7:0] THR_1V7    = 8'h66;
   localparam logic [7:0] THR_1V9    = 8'h55;
   localparam logic [7:0] THR_2V55   = 8'h33;
   localparam logic [7:0] THR_3V15   = 8'h99;
   localparam logic [7:0] THR_3V8    = 8'haa;
   localparam logic [7:0] THR_OFF    = 8'hf0;
   localparam logic [7:0] THRESH_POR = THR_1V7;

   // Reset function control codes
   localparam logic [7:0] RSTFN_IO  = 8'h55;
   localparam logic [7:0] RSTFN_PIN = 8'haa;
   localparam logic [7:0] RSTFN_POR = RSTFN_IO;

   localparam logic [7:0] SPCMD_RESET = 8'h55;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Timing
   localparam int CLK_PERIOD_NS      = 40;
   localparam int SOFT_RESET_DELAY_NS = 16000;
   localparam int LOW_SUPPLY_MIN_NS   = 120000;
   localparam int SOFT_RESET_CYCLES  = (SOFT_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOW_SUPPLY_CYCLES  = (LOW_SUPPLY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      SEL_1V7,
      SEL_1V9,
      SEL_2V55,
      SEL_3V15,
      SEL_3V8,
      SEL_OFF
   } uvr_sel_t;
endpackage : rst_src_pkg

// File: hdl/delay_if.sv
// Arm and fire pair between the reset block and its hold timers
`timescale 1ns/1ps
interface delay_if;
   logic arm;
   logic fire;
   modport owner (output arm, input fire);
   modport timer (input arm, output fire);
endinterface : delay_if

// File: hdl/hold_timer.sv
// Fires once after its arm input has stayed high for CYCLES cycles
`timescale 1ns/1ps
module hold_timer #(
   parameter int CYCLES = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   delay_if.timer   dl
);
   localparam int CW = $clog2(CYCLES + 1);

   if (CYCLES < 1) begin : g_chk
      $error("hold_timer needs CYCLES of at least one");
   end

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          fire_q;
   logic          fire_d;

   always_comb begin
      cnt_d  = cnt_q;
      fire_d = 1'b0;
      if (!dl.arm) begin
         cnt_d = '0;
      end else if (cnt_q != CW'(CYCLES)) begin
         cnt_d  = cnt_q + CW'(1);
         fire_d = (cnt_q == CW'(CYCLES - 1));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q  <= '0;
         fire_q <= 1'b0;
      end else if (ce) begin
         cnt_q  <= cnt_d;
         fire_q <= fire_d;
      end
   end

   assign dl.fire = fire_q;

   a_fire_needs_arm: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && fire_d |-> dl.arm && cnt_q == CW'(CYCLES - 1))
      else $error("timer fired without a full hold");
   a_drop_restarts: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && !dl.arm |=> cnt_q == '0 && !fire_q)
      else $error("timer did not restart on drop");
endmodule : hold_timer

// File: hdl/reset_source_and_lvr_control.sv
// Reset cause flags, threshold select and reset request logic with an AXI4-Lite slave
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module reset_source_and_lvr_control #(
   parameter int SOFT_CYCLES = rst_src_pkg::SOFT_RESET_CYCLES,
   parameter int LOW_CYCLES  = rst_src_pkg::LOW_SUPPLY_CYCLES
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  ce,
   input  wire logic [7:0]            awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   input  wire logic [7:0]            araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready,
   input  wire logic                  low_supply,
   input  wire logic                  low_power_mode,
   input  wire logic                  wdt_timeout,
   input  wire logic                  wdt_code_fault,
   input  wire logic                  res_pin_low,
   output logic                       sys_reset,
   output logic                       pc_sp_reset,
   output logic                       uvr_enable,
   output rst_src_pkg::uvr_sel_t      uvr_select,
   output logic                       reset_pin_enable,
   output logic                       irq
);
   import rst_src_pkg::*;

   if (SOFT_CYCLES < 1 || LOW_CYCLES < 1) begin : g_chk
      $error("delay counts must be at least one");
   end

   function automatic logic is_mapped(input logic [7:0] a);
      return a[1:0] == 2'h0 && a <= OFS_IRQ_EN;
   endfunction : is_mapped

   // Returns SEL_OFF for the disable code; valid says the code is defined
   function automatic uvr_sel_t decode_thr(input logic [7:0] c, output logic valid);
      valid = 1'b1;
      case (c)
         THR_1V7:  return SEL_1V7;
         THR_1V9:  return SEL_1V9;
         THR_2V55: return SEL_2V55;
         THR_3V15: return SEL_3V15;
         THR_3V8:  return SEL_3V8;
         THR_OFF:  return SEL_OFF;
         default: begin
            valid = 1'b0;
            return SEL_OFF;
         end
      endcase
   endfunction : decode_thr

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite handshake

   logic        aw_held_q, aw_held_d, w_held_q, w_held_d;
   logic [7:0]  wr_addr_q, wr_addr_d;
   logic [31:0] wr_data_q, wr_data_d;
   logic        wr_lane_q, wr_lane_d;
   logic        awready_q, awready_d, wready_q, wready_d;
   logic        bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
   logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic        do_write, ar_take;

   always_comb begin
      aw_held_d = aw_held_q;
      w_held_d  = w_held_q;
      wr_addr_d = wr_addr_q;
      wr_data_d = wr_data_q;
      wr_lane_d = wr_lane_q;
      if (awvalid && awready_q) begin
         aw_held_d = 1'b1;
         wr_addr_d = awaddr;
      end
      if (wvalid && wready_q) begin
         w_held_d  = 1'b1;
         wr_data_d = wdata;
         wr_lane_d = wstrb[0];
      end
      do_write = aw_held_q && w_held_q && !bvalid_q;
      if (do_write) begin
         aw_held_d = 1'b0;
         w_held_d  = 1'b0;
      end
      bvalid_d  = do_write || (bvalid_q && !bready);
      bresp_d   = do_write ? (is_mapped(wr_addr_q) ? RESP_OKAY : RESP_SLVERR) : bresp_q;
      awready_d = !aw_held_d && !bvalid_d;
      wready_d  = !w_held_d && !bvalid_d;
      ar_take   = arvalid && arready_q;
      rvalid_d  = ar_take || (rvalid_q && !rready);
      arready_d = !rvalid_d;
      rresp_d   = ar_take ? (is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR) : rresp_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset sources

   logic [7:0]      thresh_q, thresh_d, rstfn_q, rstfn_d, spcmd_q, spcmd_d;
   logic [3:0]      cause_q, cause_d;
   logic            timeout_q, timeout_d, pdn_q, pdn_d;
   logic [EV_W-1:0] ev_stat_q, ev_stat_d, ev_en_q, ev_en_d, ev_set;
   logic            sys_reset_q, sys_reset_d, pc_sp_q, pc_sp_d;
   logic            uvr_en_q, uvr_en_d, pin_en_q, pin_en_d, irq_q, irq_d;
   uvr_sel_t        sel_q, sel_d, sel_now;
   logic            thr_valid, bad_thr, bad_rstfn, uvr_arm;
   logic            soft_fire, uvr_fire, iap_hit, wdt_run, wdt_sleep, pin_rst;
   logic            wr_ok;

   delay_if soft_dl ();
   delay_if low_dl ();

   hold_timer #(.CYCLES(SOFT_CYCLES)) u_soft_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .dl      (soft_dl.timer)
   );

   hold_timer #(.CYCLES(LOW_CYCLES)) u_low_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .dl      (low_dl.timer)
   );

   always_comb begin
      sel_now   = decode_thr(thresh_q, thr_valid);
      bad_thr   = !thr_valid;
      bad_rstfn = rstfn_q != RSTFN_IO && rstfn_q != RSTFN_PIN;
      // Comparator disabled by the code or by sleep/idle
      uvr_arm   = thr_valid && sel_now != SEL_OFF && !low_power_mode && low_supply;
   end

   assign soft_dl.arm = bad_thr || bad_rstfn;
   assign low_dl.arm  = uvr_arm;

   always_comb begin
      soft_fire = soft_dl.fire;
      uvr_fire  = low_dl.fire;
      wr_ok     = do_write && wr_lane_q;
      iap_hit   = wr_ok && wr_addr_q == OFS_SPCMD && wr_data_q[7:0] == SPCMD_RESET;
      wdt_run   = wdt_timeout && !low_power_mode;
      wdt_sleep = wdt_timeout && low_power_mode;
      pin_rst   = res_pin_low && rstfn_q == RSTFN_PIN;
      ev_set    = '0;
      ev_set[EV_CTRL]    = soft_fire && bad_rstfn;
      ev_set[EV_UVR]     = uvr_fire;
      ev_set[EV_THR]     = soft_fire && bad_thr;
      ev_set[EV_WDTCODE] = wdt_code_fault;
      ev_set[EV_WDT]     = wdt_timeout;
      ev_set[EV_IAP]     = iap_hit;
   end

   always_comb begin
      thresh_d  = thresh_q;
      rstfn_d   = rstfn_q;
      spcmd_d   = spcmd_q;
      cause_d   = cause_q;
      ev_en_d   = ev_en_q;
      ev_stat_d = ev_stat_q;
      timeout_d = timeout_q;
      pdn_d     = pdn_q;
      // Software writes first so hardware sets below win over clears
      if (wr_ok) begin
         case (wr_addr_q)
            OFS_CAUSE:   cause_d   = cause_q & wr_data_q[3:0];
            OFS_THRESH:  thresh_d  = wr_data_q[7:0];
            OFS_RSTFN:   rstfn_d   = wr_data_q[7:0];
            OFS_SPCMD:   spcmd_d   = wr_data_q[7:0];
            OFS_IRQ_CLR: ev_stat_d = ev_stat_q & ~wr_data_q[EV_W-1:0];
            OFS_IRQ_EN:  ev_en_d   = wr_data_q[EV_W-1:0];
            default: ;
         endcase
      end
      ev_stat_d = ev_stat_d | ev_set;
      if (soft_fire && bad_rstfn) begin
         cause_d[CAUSE_CTRL] = 1'b1;
      end
      if (soft_fire && bad_thr) begin
         cause_d[CAUSE_THR] = 1'b1;
         thresh_d = THRESH_POR;
      end
      if (uvr_fire) begin
         cause_d[CAUSE_UVR] = 1'b1;
      end
      if (wdt_code_fault) begin
         cause_d[CAUSE_WDT] = 1'b1;
      end
      if (wdt_timeout) begin
         timeout_d = 1'b1;
      end
      if (wdt_sleep) begin
         pdn_d = 1'b1;
      end
      sys_reset_d = soft_fire || uvr_fire || iap_hit || wdt_run || pin_rst;
      // Control code returns to default on every full reset
      if (sys_reset_d) begin
         rstfn_d = RSTFN_POR;
      end
      // Sleep timeout is a warm restart: pc_sp_reset only, no sys_reset; timeout and power-down flags still set
      pc_sp_d  = wdt_sleep;
      sel_d    = decode_thr(thresh_d, uvr_en_d);
      uvr_en_d = uvr_en_d && sel_d != SEL_OFF;
      pin_en_d = rstfn_d == RSTFN_PIN;
      irq_d    = |(ev_stat_d & ev_en_d);
      rdata_d  = rdata_q;
      if (ar_take) begin
         rdata_d = '0;
         case (araddr)
            OFS_CAUSE:    rdata_d[3:0]      = cause_q;
            OFS_THRESH:   rdata_d[7:0]      = thresh_q;
            OFS_RSTFN:    rdata_d[7:0]      = rstfn_q;
            OFS_SPCMD:    rdata_d[7:0]      = spcmd_q;
            OFS_STATUS:   rdata_d[1:0]      = {pdn_q, timeout_q};
            OFS_IRQ_STAT: rdata_d[EV_W-1:0] = ev_stat_q;
            OFS_IRQ_EN:   rdata_d[EV_W-1:0] = ev_en_q;
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q   <= 1'b0;
         w_held_q    <= 1'b0;
         wr_addr_q   <= '0;
         wr_data_q   <= '0;
         wr_lane_q   <= 1'b0;
         awready_q   <= 1'b0;
         wready_q    <= 1'b0;
         bvalid_q    <= 1'b0;
         bresp_q     <= RESP_OKAY;
         arready_q   <= 1'b0;
         rvalid_q    <= 1'b0;
         rresp_q     <= RESP_OKAY;
         rdata_q     <= '0;
         thresh_q    <= THRESH_POR;
         rstfn_q     <= RSTFN_POR;
         spcmd_q     <= '0;
         cause_q     <= '0;
         timeout_q   <= 1'b0;
         pdn_q       <= 1'b0;
         ev_stat_q   <= '0;
         ev_en_q     <= '0;
         // Full reset held while power-on is low: core, timers, watchdog and ports follow it
         sys_reset_q <= 1'b1;
         pc_sp_q     <= 1'b0;
         uvr_en_q    <= 1'b1;
         sel_q       <= SEL_1V7;
         pin_en_q    <= 1'b0;
         irq_q       <= 1'b0;
      end else if (ce) begin
         aw_held_q   <= aw_held_d;
         w_held_q    <= w_held_d;
         wr_addr_q   <= wr_addr_d;
         wr_data_q   <= wr_data_d;
         wr_lane_q   <= wr_lane_d;
         awready_q   <= awready_d;
         wready_q    <= wready_d;
         bvalid_q    <= bvalid_d;
         bresp_q     <= bresp_d;
         arready_q   <= arready_d;
         rvalid_q    <= rvalid_d;
         rresp_q     <= rresp_d;
         rdata_q     <= rdata_d;
         thresh_q    <= thresh_d;
         rstfn_q     <= rstfn_d;
         spcmd_q     <= spcmd_d;
         cause_q     <= cause_d;
         timeout_q   <= timeout_d;
         pdn_q       <= pdn_d;
         ev_stat_q   <= ev_stat_d;
         ev_en_q     <= ev_en_d;
         sys_reset_q <= sys_reset_d;
         pc_sp_q     <= pc_sp_d;
         uvr_en_q    <= uvr_en_d;
         sel_q       <= sel_d;
         pin_en_q    <= pin_en_d;
         irq_q       <= irq_d;
      end
   end

   assign awready          = awready_q;
   assign wready           = wready_q;
   assign bvalid           = bvalid_q;
   assign bresp            = bresp_q;
   assign arready          = arready_q;
   assign rvalid           = rvalid_q;
   assign rresp            = rresp_q;
   assign rdata            = rdata_q;
   assign sys_reset        = sys_reset_q;
   assign pc_sp_reset      = pc_sp_q;
   assign uvr_enable       = uvr_en_q;
   assign uvr_select       = sel_q;
   assign reset_pin_enable = pin_en_q;
   assign irq              = irq_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_cause_upper_zero: assert property (ce && ar_take && araddr == OFS_CAUSE |=> rdata_q[31:4] == '0)
      else $error("cause read shows upper bits");
   a_ctrl_flag_set: assert property (ce && soft_fire && bad_rstfn |=> cause_q[CAUSE_CTRL] && sys_reset_q)
      else $error("control code reset left flag clear");
   a_uvr_sleep_off: assert property (low_power_mode |-> !low_dl.arm)
      else $error("low voltage reset armed in sleep");
   a_uvr_flag_reset: assert property (ce && uvr_fire |=> cause_q[CAUSE_UVR] && sys_reset_q)
      else $error("low voltage reset not flagged");
   a_flags_sticky: assert property (ce && !(wr_ok && wr_addr_q == OFS_CAUSE) |=> cause_q == ($past(cause_q) | cause_q))
      else $error("cause flag fell without a write");
   a_bad_thr_default: assert property (ce && soft_fire && bad_thr |=> thresh_q == THRESH_POR && cause_q[CAUSE_THR])
      else $error("bad threshold not restored");
   a_uvr_keeps_thr: assert property (ce && uvr_fire && !soft_fire && !wr_ok |=> $stable(thresh_q))
      else $error("threshold changed by low voltage reset");
   a_iap_reset: assert property (ce && iap_hit |=> sys_reset_q)
      else $error("self program command gave no reset");
   a_wdt_run: assert property (ce && wdt_run |=> sys_reset_q && timeout_q && !pc_sp_q)
      else $error("run mode timeout handled wrongly");
   a_wdt_sleep: assert property (ce && wdt_sleep |=> pc_sp_q && timeout_q && pdn_q && $stable(thresh_q))
      else $error("sleep timeout handled wrongly");
   a_por_state: assert property ($rose(aresetn) |-> sys_reset_q && thresh_q == THRESH_POR && !timeout_q && !pdn_q)
      else $error("power-on state wrong");

   c_uvr_reset: cover property (ce && uvr_fire);
   c_thr_reset: cover property (ce && soft_fire && bad_thr);
   c_wdt_sleep: cover property (ce && wdt_sleep);
   c_iap_reset: cover property (ce && iap_hit);
endmodule : reset_source_and_lvr_control

// File: test/testbench.sv
// Self-checking bench for the reset-source block, driven over AXI4-Lite
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin err_count++; \
   $display("BAD %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
   import rst_src_pkg::*;
   // Short delays keep the run brief; expectations follow from these
   localparam int SOFT = 4;
   localparam int LOW  = 5;
   localparam logic [7:0] CODES [6] = '{THR_1V7, THR_1V9, THR_2V55, THR_3V15, THR_3V8, THR_OFF};
   localparam uvr_sel_t   SELS  [6] = '{SEL_1V7, SEL_1V9, SEL_2V55, SEL_3V15, SEL_3V8, SEL_OFF};
   // Event pin masks for pulse, ordered pin, code fault, timeout, supply
   localparam logic [3:0] P_SUPPLY = 4'h1;
   localparam logic [3:0] P_WDT    = 4'h2;
   localparam logic [3:0] P_CODE   = 4'h4;
   localparam logic [3:0] P_PIN    = 4'h8;
   logic        aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, low_supply, low_power_mode, wdt_timeout;
   logic        wdt_code_fault, res_pin_low, sys_reset, pc_sp_reset, uvr_enable, reset_pin_enable, irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd_val;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp_val;
   uvr_sel_t    uvr_select;
   int          err_count, checked, rst_cnt, pcsp_cnt, base, pbase;

   reset_source_and_lvr_control #(.SOFT_CYCLES(SOFT), .LOW_CYCLES(LOW)) reset_source_and_lvr_control_i (
      .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .low_supply, .low_power_mode, .wdt_timeout, .wdt_code_fault, .res_pin_low, .sys_reset,
      .pc_sp_reset, .uvr_enable, .uvr_select, .reset_pin_enable, .irq);

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      if (aresetn && sys_reset === 1'b1) rst_cnt++;
      if (pc_sp_reset === 1'b1) pcsp_cnt++;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : stop_test

   // Counts are read a step past the edge so the monitor has already run
   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask : idle

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 100);
      resp_val = bresp;
      bready <= 1'b0;
      if (n >= 100) err_count++;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 100);
      rd_val   = rdata;
      resp_val = rresp;
      rready <= 1'b0;
      if (n >= 100) err_count++;
   endtask : rd

   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      rd(a);
      `CHK(nm, e, rd_val)
   endtask : rchk

   // Mask instead of a ref argument: nonblocking writes through ref are not portable
   task automatic pulse(input logic [3:0] m, input int n);
      @(posedge aclk);
      {res_pin_low, wdt_code_fault, wdt_timeout, low_supply} <= m;
      repeat (n) @(posedge aclk);
      {res_pin_low, wdt_code_fault, wdt_timeout, low_supply} <= 4'h0;
      idle(3 * SOFT);
   endtask : pulse

   task automatic done(input string nm);
      $display("test %s finished", nm);
   endtask : done

   task automatic por;
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      `CHK("sys_reset_in_por", 1'b1, sys_reset)
      aresetn <= 1'b1;
      idle(3);
   endtask : por

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge aclk);
      err_count++;
      stop_test();
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {low_supply, low_power_mode, wdt_timeout, wdt_code_fault, res_pin_low} = '0;
      {awaddr, araddr, wdata} = '0;
      ce    = 1'b1;
      wstrb = 4'hf;
      por();
      rchk(OFS_CAUSE, 32'h0, "cause_por");
      rchk(OFS_THRESH, 32'h66, "thresh_por");
      rchk(OFS_RSTFN, 32'h55, "rstfn_por");
      rchk(OFS_STATUS, 32'h0, "status_por");
      `CHK("sel_por", SEL_1V7, uvr_select)
      done("power_on");
      base = rst_cnt;
      for (int i = 0; i < 6; i++) begin
         wr(OFS_THRESH, {24'h0, CODES[i]});
         idle(2);
         `CHK("uvr_select", SELS[i], uvr_select)
         `CHK("uvr_enable", (i != 5) ? 1'b1 : 1'b0, uvr_enable)
      end
      `CHK("codes_no_reset", 0, rst_cnt - base)
      wr(OFS_THRESH, 32'h12);
      idle(3 * SOFT);
      `CHK("thr_reset", 1, rst_cnt - base)
      rchk(OFS_THRESH, 32'h66, "thr_default");
      rchk(OFS_CAUSE, 32'h2, "thr_flag");
      done("threshold");
      wr(OFS_RSTFN, 32'h0);
      idle(3 * SOFT);
      `CHK("ctrl_reset", 2, rst_cnt - base)
      rchk(OFS_RSTFN, 32'h55, "ctrl_default");
      rchk(OFS_CAUSE, 32'ha, "ctrl_flag");
      wr(OFS_RSTFN, 32'haa);
      idle(2);
      `CHK("pin_enable", 1'b1, reset_pin_enable)
      base = rst_cnt;
      pulse(P_PIN, 3);
      `CHK("pin_reset", 1'b1, rst_cnt > base)
      rchk(OFS_RSTFN, 32'h55, "pin_ctrl_default");
      rchk(OFS_STATUS, 32'h0, "pin_status");
      done("control");
      wr(OFS_THRESH, 32'h33);
      base = rst_cnt;
      // One cycle short of the qualifying span must be ignored
      pulse(P_SUPPLY, LOW - 1);
      `CHK("short_low", 0, rst_cnt - base)
      @(posedge aclk);
      low_power_mode <= 1'b1;
      pulse(P_SUPPLY, 3 * LOW);
      `CHK("sleep_low", 0, rst_cnt - base)
      @(posedge aclk);
      low_power_mode <= 1'b0;
      pulse(P_SUPPLY, 3 * LOW);
      `CHK("uvr_reset", 1, rst_cnt - base)
      rchk(OFS_THRESH, 32'h33, "uvr_keeps_thr");
      rchk(OFS_CAUSE, 32'he, "uvr_flag");
      rchk(OFS_STATUS, 32'h0, "uvr_status");
      wr(OFS_CAUSE, 32'hf4);
      rchk(OFS_CAUSE, 32'h4, "cause_partial_clear");
      wr(OFS_CAUSE, 32'h0);
      rchk(OFS_CAUSE, 32'h0, "cause_clear");
      pulse(P_CODE, 1);
      rchk(OFS_CAUSE, 32'h1, "wdt_code_flag");
      done("low_voltage");
      base = rst_cnt;
      pbase = pcsp_cnt;
      pulse(P_WDT, 1);
      `CHK("wdt_run_reset", 1, rst_cnt - base)
      rchk(OFS_STATUS, 32'h1, "wdt_run_status");
      // Clock enable low freezes the block, so a timeout then is lost
      @(posedge aclk);
      ce <= 1'b0;
      pulse(P_WDT, 1);
      `CHK("ce_frozen", 1, rst_cnt - base)
      @(posedge aclk);
      ce <= 1'b1;
      @(posedge aclk);
      low_power_mode <= 1'b1;
      pulse(P_WDT, 1);
      `CHK("wdt_sleep_pcsp", 1, pcsp_cnt - pbase)
      `CHK("wdt_sleep_nofull", 1, rst_cnt - base)
      rchk(OFS_STATUS, 32'h3, "wdt_sleep_status");
      rchk(OFS_THRESH, 32'h33, "wdt_sleep_thr");
      @(posedge aclk);
      low_power_mode <= 1'b0;
      done("watchdog");
      wr(OFS_SPCMD, 32'h54);
      idle(3);
      `CHK("spcmd_other", 1, rst_cnt - base)
      wr(OFS_SPCMD, 32'h55);
      idle(3);
      `CHK("spcmd_reset", 2, rst_cnt - base)
      // Lane zero strobe off: the bad code must not land
      @(posedge aclk);
      wstrb <= 4'he;
      wr(OFS_THRESH, 32'h12);
      rchk(OFS_THRESH, 32'h33, "masked_write");
      wstrb <= 4'hf;
      done("self_program");
      wr(OFS_IRQ_EN, 32'h1 << EV_THR);
      idle(2);
      `CHK("irq_on", 1'b1, irq)
      rchk(OFS_IRQ_STAT, 32'h3f, "irq_status");
      wr(OFS_IRQ_EN, 32'h0);
      idle(2);
      `CHK("irq_masked", 1'b0, irq)
      wr(OFS_IRQ_CLR, 32'h3f);
      wr(OFS_IRQ_EN, 32'h3f);
      idle(2);
      `CHK("irq_cleared", 1'b0, irq)
      rchk(OFS_IRQ_STAT, 32'h0, "irq_status_clr");
      wr(8'h20, 32'h0);
      `CHK("unmapped_bresp", RESP_SLVERR, resp_val)
      rd(8'h22);
      `CHK("unaligned_rresp", RESP_SLVERR, resp_val)
      done("interrupt_bus");
      por();
      rchk(OFS_THRESH, 32'h66, "thr_second_por");
      rchk(OFS_STATUS, 32'h0, "status_second_por");
      rchk(OFS_CAUSE, 32'h0, "cause_second_por");
      done("second_reset");
      stop_test();
   end
endmodule : testbench
